// [hw/dcmp_top.sv]
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - On bit enables comparator; off saves power.
// - Two-bit field picks minus input source.
// - 11 bandgap, 10 other B, 01 C, 00 first B.
// - Plus source bit: pin A or ladder.
// - Result high when plus exceeds minus.
// - Invert bit flips result everywhere downstream.
// - Result register bits 6 and 7, read-only.
// - Output enable routes result to port pin.
// - Port direction bits still gate pin drivers.
// - 01 rising, 10 falling sets flag.
// - Edges seen after polarity adjustment.
// - 11 sets flag on any change.
// - 00 never sets flag.
// - Flag sticks until software writes zero.
// - Writing one to flag sets it.
// - Request needs comparator, peripheral, global enables.
// - Flags set regardless of enable bits.
// - Reset returns both setup registers, comparators off.
// - Enabled comparator keeps working and wakes in sleep.
module dcmp_top
    import dcmp_pkg::*;
(
    // Clock and asynchronous reset.
    input  wire logic       clk,
    input  wire logic       nrst,
    // Register port.
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    // Analog comparator results, one per comparator.
    input  wire logic [1:0] rawResult,
    // Analog front-end controls, bit 0 is comparator 1.
    output logic      [1:0] cmpPowerOn,
    output logic      [1:0] plusInputSourceSelect,
    output logic      [1:0] minusSelFirst,
    output logic      [1:0] minusSelSecond,
    // Port E output pins: bit 0 first pin, bit 1 second pin.
    output logic      [1:0] pinOut,
    output logic      [1:0] pinOe,
    output logic      [1:0] pinMuxSel,
    // Interrupt request, also the wake from sleep.
    output logic            irqReq
);

    logic       rstSyncA_q, rstSyncB_q;
    logic       rstN;
    logic [7:0] setup_q [2];
    logic [7:0] setup_d [2];
    logic [1:0] flag_q,   flag_d;
    logic [1:0] irqEn_q,  irqEn_d;
    logic       periphEn_q, periphEn_d;
    logic       globalEn_q, globalEn_d;
    logic [7:0] portDir_q, portDir_d;
    logic [7:0] rdata_q,  rdata_d;
    logic [1:0] result;
    logic [1:0] cmpEvent;
    logic [1:0] pinOut_q, pinOut_d;
    logic [1:0] pinOe_q,  pinOe_d;
    logic [1:0] mux_q,    mux_d;
    logic [1:0] power_q,  power_d;
    logic [1:0] plus_q,   plus_d;
    logic [1:0] minA_q,   minA_d;
    logic [1:0] minB_q,   minB_d;
    logic       irq_q,    irq_d;

    // Reset enters asynchronously but is released in step with clk.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstSyncA_q <= 1'b0;
            rstSyncB_q <= 1'b0;
        end else begin
            rstSyncA_q <= 1'b1;
            rstSyncB_q <= rstSyncA_q;
        end
    end
    assign rstN = rstSyncB_q;

    // One digital path per comparator.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            dcmp_channel u_ch (
                .clk       (clk),
                .rstN      (rstN),
                .enable    (setup_q[gi][SETUP_ON_BIT]),
                .invert    (setup_q[gi][SETUP_INV_BIT]),
                .edgeSel   (setup_q[gi][SETUP_EVT_HI:SETUP_EVT_LO]),
                .rawResult (rawResult[gi]),
                .result    (result[gi]),
                .event_o   (cmpEvent[gi])
            );
        end
    endgenerate

    // Register writes; hardware events win over a clearing write.
    always_comb begin
        setup_d    = setup_q;
        irqEn_d    = irqEn_q;
        periphEn_d = periphEn_q;
        globalEn_d = globalEn_q;
        portDir_d  = portDir_q;
        flag_d     = flag_q;
        if (regWr) begin
            unique case (regAddr)
                SETUP1_ADDR: setup_d[0] = regWdata;
                SETUP2_ADDR: setup_d[1] = regWdata;
                FLAG_ADDR: begin
                    flag_d[0] = regWdata[FLAG_CMP1_BIT];
                    flag_d[1] = regWdata[FLAG_CMP2_BIT];
                end
                ENABLE_ADDR: begin
                    irqEn_d[0] = regWdata[FLAG_CMP1_BIT];
                    irqEn_d[1] = regWdata[FLAG_CMP2_BIT];
                end
                CORE_ADDR: begin
                    periphEn_d = regWdata[CORE_PERIPH_BIT];
                    globalEn_d = regWdata[CORE_GLOBAL_BIT];
                end
                PORTE_ADDR: portDir_d = regWdata;
                default: ;
            endcase
        end
        // Enables play no part in setting the flags.
        flag_d = flag_d | cmpEvent;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            setup_q[0] <= SETUP_RESET;
            setup_q[1] <= SETUP_RESET;
            flag_q     <= 2'h0;
            irqEn_q    <= 2'h0;
            periphEn_q <= 1'b0;
            globalEn_q <= 1'b0;
            portDir_q  <= PORTE_RESET;
        end else begin
            setup_q    <= setup_d;
            flag_q     <= flag_d;
            irqEn_q    <= irqEn_d;
            periphEn_q <= periphEn_d;
            globalEn_q <= globalEn_d;
            portDir_q  <= portDir_d;
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads zero.
    always_comb begin
        rdata_d = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                SETUP1_ADDR: rdata_d = setup_q[0];
                SETUP2_ADDR: rdata_d = setup_q[1];
                RESULT_ADDR: begin
                    rdata_d[RESULT_CMP1_BIT] = result[0];
                    rdata_d[RESULT_CMP2_BIT] = result[1];
                end
                FLAG_ADDR: begin
                    rdata_d[FLAG_CMP1_BIT] = flag_q[0];
                    rdata_d[FLAG_CMP2_BIT] = flag_q[1];
                end
                ENABLE_ADDR: begin
                    rdata_d[FLAG_CMP1_BIT] = irqEn_q[0];
                    rdata_d[FLAG_CMP2_BIT] = irqEn_q[1];
                end
                CORE_ADDR: begin
                    rdata_d[CORE_PERIPH_BIT] = periphEn_q;
                    rdata_d[CORE_GLOBAL_BIT] = globalEn_q;
                end
                PORTE_ADDR: rdata_d = portDir_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Analog controls, pin routing and interrupt, all registered.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            power_d[i] = setup_q[i][SETUP_ON_BIT];
            plus_d[i]  = setup_q[i][SETUP_PLUS_BIT];
            // Minus select goes as a code; the analog mux decodes it.
            minA_d[i]  = setup_q[i][SETUP_MINUS_LO];
            minB_d[i]  = setup_q[i][SETUP_MINUS_HI];
            mux_d[i]   = setup_q[i][SETUP_OE_BIT];
            // Result of a routed pin; the port value when not routed is
            // outside this block, so the pin then shows low.
            pinOut_d[i] = setup_q[i][SETUP_OE_BIT] & result[i];
        end
        // Direction bit set means input, so the driver stays off.
        pinOe_d[0] = ~portDir_q[PORTE_CMP1_BIT];
        pinOe_d[1] = ~portDir_q[PORTE_CMP2_BIT];
        // Flag feeds the request through a register, so the request follows a cycle later.
        irq_d = globalEn_q & periphEn_q
              & |(flag_q & irqEn_q);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdata_q  <= 8'h00;
            power_q  <= 2'h0;
            plus_q   <= 2'h0;
            minA_q   <= 2'h0;
            minB_q   <= 2'h0;
            mux_q    <= 2'h0;
            pinOut_q <= 2'h0;
            pinOe_q  <= 2'h0;
            irq_q    <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            power_q  <= power_d;
            plus_q   <= plus_d;
            minA_q   <= minA_d;
            minB_q   <= minB_d;
            mux_q    <= mux_d;
            pinOut_q <= pinOut_d;
            pinOe_q  <= pinOe_d;
            irq_q    <= irq_d;
        end
    end

    assign regRdata              = rdata_q;
    assign cmpPowerOn            = power_q;
    assign plusInputSourceSelect = plus_q;
    assign minusSelFirst         = minA_q;
    assign minusSelSecond        = minB_q;
    assign pinMuxSel             = mux_q;
    assign pinOut                = pinOut_q;
    assign pinOe                 = pinOe_q;
    assign irqReq                = irq_q;

endmodule

// [hw/dcmp_pkg.sv]
package dcmp_pkg;

    // Register word offsets on the plain register port.
    localparam logic [2:0] SETUP1_ADDR  = 3'h0;
    localparam logic [2:0] SETUP2_ADDR  = 3'h1;
    localparam logic [2:0] RESULT_ADDR  = 3'h2;
    localparam logic [2:0] FLAG_ADDR    = 3'h3;
    localparam logic [2:0] ENABLE_ADDR  = 3'h4;
    localparam logic [2:0] CORE_ADDR    = 3'h5;
    localparam logic [2:0] PORTE_ADDR   = 3'h6;

    // Setup register fields.
    localparam int SETUP_ON_BIT    = 7;
    localparam int SETUP_OE_BIT    = 6;
    localparam int SETUP_INV_BIT   = 5;
    localparam int SETUP_EVT_HI    = 4;
    localparam int SETUP_EVT_LO    = 3;
    localparam int SETUP_PLUS_BIT  = 2;
    localparam int SETUP_MINUS_HI  = 1;
    localparam int SETUP_MINUS_LO  = 0;
    localparam logic [7:0] SETUP_RESET = 8'h1f;

    // Result register fields.
    localparam int RESULT_CMP1_BIT = 6;
    localparam int RESULT_CMP2_BIT = 7;

    // Flag and enable register fields (comparator 1 on 4, 2 on 5).
    localparam int FLAG_CMP1_BIT   = 4;
    localparam int FLAG_CMP2_BIT   = 5;

    // Interrupt core register fields.
    localparam int CORE_PERIPH_BIT = 6;
    localparam int CORE_GLOBAL_BIT = 7;

    // Port E direction bits for the two output pins (1 = input).
    localparam int PORTE_CMP1_BIT  = 1;
    localparam int PORTE_CMP2_BIT  = 2;
    localparam logic [7:0] PORTE_RESET = 8'hff;

    // Event edge select encodings.
    typedef enum logic [1:0] {
        DCMP_EVT_NONE = 2'b00,
        DCMP_EVT_RISE = 2'b01,
        DCMP_EVT_FALL = 2'b10,
        DCMP_EVT_ANY  = 2'b11
    } dcmp_evt_t;

    // Minus-input channel encodings.
    typedef enum logic [1:0] {
        DCMP_MIN_FIRST_B  = 2'b00,
        DCMP_MIN_OWN_C    = 2'b01,
        DCMP_MIN_SECOND_B = 2'b10,
        DCMP_MIN_BANDGAP  = 2'b11
    } dcmp_min_t;

endpackage

// [hw/dcmp_channel.sv]
`timescale 1ns/1ns
// One comparator's digital path: synchroniser, polarity and edge events.
module dcmp_channel
    import dcmp_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstN,
    // Configuration.
    input  wire logic       enable,
    input  wire logic       invert,
    input  wire logic [1:0] edgeSel,
    // Raw asynchronous comparator result.
    input  wire logic       rawResult,
    // Polarity-adjusted result and one-cycle event.
    output logic            result,
    output logic            event_o
);

    logic syncA_q, syncA_d;
    logic syncB_q, syncB_d;
    logic prev_q,  prev_d;
    logic adjusted;
    logic rise, fall;

    // Gated comparator is held at the invert bit so a disabled one makes no noise.
    assign adjusted = (syncB_q & enable) ^ invert;
    assign result   = adjusted;

    // Two flip-flops tame the analog edge; the first feeds only the second.
    always_comb begin
        syncA_d = rawResult;
        syncB_d = syncA_q;
        prev_d  = adjusted;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
            prev_q  <= prev_d;
        end
    end

    // Compare this sample with the last one to find edges.
    assign rise = adjusted & ~prev_q;
    assign fall = ~adjusted & prev_q;

    always_comb begin
        unique case (dcmp_evt_t'(edgeSel))
            DCMP_EVT_NONE: event_o = 1'b0;
            DCMP_EVT_RISE: event_o = rise;
            DCMP_EVT_FALL: event_o = fall;
            DCMP_EVT_ANY:  event_o = rise | fall;
        endcase
    end

endmodule

// [test/dcmp_front.sv]
`timescale 1ns/1ns
// Analog front end: input routing and the comparison itself.
module dcmp_front (
    // Controls from the block, bit 0 is comparator 1.
    input  wire logic [1:0]  cmpPowerOn,
    input  wire logic [1:0]  plusSel,
    input  wire logic [1:0]  minusLo,
    input  wire logic [1:0]  minusHi,
    // Source levels: A1 A2 C1 C2 B1 B2 bandgap ladder, low byte first.
    input  wire logic [63:0] volts,
    // Raw results.
    output logic      [1:0]  rawResult
);
    // The result ignores the on bit, so a block that fails to mask a
    // switched-off comparator is caught.
    // Each chosen minus pin is treated as a configured analog input.
    always_comb begin
        logic [7:0] p;
        logic [7:0] m;
        p = 8'h00;
        m = 8'h00;
        rawResult = 2'h0;
        for (int c = 0; c < 2; c++) begin
            p = plusSel[c] ? volts[63:56] : volts[c*8+:8];
            case ({minusHi[c], minusLo[c]})
                2'b00: m = volts[39:32];
                2'b01: m = volts[(2+c)*8+:8];
                2'b10: m = volts[47:40];
                default: m = volts[55:48];
            endcase
            rawResult[c] = p > m;
        end
    end
endmodule

// [test/dcmp_props.sv]
`timescale 1ns/1ns
// Watches the block's ports for timing and routing slips.
module dcmp_props
    import dcmp_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       nrst,
    // Register port.
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic [7:0] regRdata,
    // Front end, pins and request.
    input  wire logic [1:0] rawResult,
    input  wire logic [1:0] cmpPowerOn,
    input  wire logic [1:0] plusInputSourceSelect,
    input  wire logic [1:0] minusSelFirst,
    input  wire logic [1:0] minusSelSecond,
    input  wire logic [1:0] pinOut,
    input  wire logic [1:0] pinOe,
    input  wire logic [1:0] pinMuxSel,
    input  wire logic       irqReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Outputs lag a register write by two edges, hence the depth of 2.
    a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside its slot");
    a_result_bits: assert property ($past(regRd) &&
        $past(regAddr) == RESULT_ADDR |-> regRdata[5:0] == 6'h00)
        else $error("result low bits not zero");
    a_pin_mux: assert property ((pinOut & ~pinMuxSel) == 2'h0)
        else $error("pin driven while not routed");
    a_reset_off: assert property ($rose(nrst) |->
        (cmpPowerOn == 2'h0 && irqReq == 1'b0)[*3])
        else $error("comparator on after reset");
    a_reset_sel: assert property ($rose(nrst) |->
        ##[2:5] (minusSelFirst & minusSelSecond) == 2'h3)
        else $error("minus select not reset value");
    a_reset_pins: assert property ($rose(nrst) |->
        (pinOe == 2'h0 && pinMuxSel == 2'h0)[*3])
        else $error("pin enabled after reset");
    a_dir_gate: assert property ($past(regWr, 2) &&
        $past(regAddr, 2) == PORTE_ADDR |->
        pinOe == ~{$past(regWdata[2], 2), $past(regWdata[1], 2)})
        else $error("pin enable not from direction bits");
    a_setup_out: assert property ($past(regWr, 2) &&
        $past(regAddr, 2) == SETUP1_ADDR |->
        {cmpPowerOn[0], pinMuxSel[0], plusInputSourceSelect[0],
         minusSelSecond[0], minusSelFirst[0]} ==
        {$past(regWdata[7:6], 2), $past(regWdata[2:0], 2)})
        else $error("setup fields not on front end");
    a_irq_gate: assert property ($past(regWr, 2) &&
        $past(regAddr, 2) == CORE_ADDR && !(&$past(regWdata[7:6], 2))
        |-> !irqReq)
        else $error("request with core enable clear");
    c_irq: cover property ($rose(irqReq));
    c_pin: cover property (pinOut[0] && pinOe[0]);
    c_res: cover property ($past(regRd) && regRdata[6]);
endmodule
bind dcmp_top dcmp_props u_props (.clk(clk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rawResult(rawResult), .cmpPowerOn(cmpPowerOn),
    .plusInputSourceSelect(plusInputSourceSelect), .pinOut(pinOut),
    .minusSelFirst(minusSelFirst), .minusSelSecond(minusSelSecond),
    .pinOe(pinOe), .pinMuxSel(pinMuxSel), .irqReq(irqReq));

// [test/tb_dcmp_top.sv]
`timescale 1ns/1ns
// Self-checking bench for the comparator block.
module tb_dcmp_top;
    import dcmp_pkg::*;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  regAddr = 3'h0;
    logic [7:0]  regWdata = 8'h00;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [7:0]  regRdata;
    // Levels chosen so minus code 11 always differs from codes 00 and 10, which give the same; code 01 varies.
    logic [63:0] volts = 64'h5560_2030_2550_4540;
    logic [1:0]  rawResult, cmpPowerOn, plusSel, minLo, minHi;
    logic [1:0]  pinOut, pinOe, pinMuxSel;
    logic        irqReq;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #25 clk = ~clk;
    dcmp_top uut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .rawResult(rawResult), .cmpPowerOn(cmpPowerOn),
        .plusInputSourceSelect(plusSel), .minusSelFirst(minLo),
        .minusSelSecond(minHi), .pinOut(pinOut), .pinOe(pinOe),
        .pinMuxSel(pinMuxSel), .irqReq(irqReq));
    dcmp_front front (.cmpPowerOn(cmpPowerOn), .plusSel(plusSel),
        .minusLo(minLo), .minusHi(minHi), .volts(volts),
        .rawResult(rawResult));
    // Expected comparison from the source levels.
    function automatic logic exp_res(int c, int p, int k);
        logic [7:0] s;
        logic [7:0] m;
        s = p ? volts[63:56] : volts[c*8+:8];
        m = k == 0 ? volts[39:32] : k == 1 ? volts[(2+c)*8+:8]
          : k == 2 ? volts[47:40] : volts[55:48];
        return s > m;
    endfunction
    // Ends 1 ns past the edge so that edge's updates have landed.
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rchk(logic [2:0] a, logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK("rdata", e, regRdata)
    endtask
    task automatic t_reset();
        rchk(SETUP1_ADDR, SETUP_RESET);
        rchk(SETUP2_ADDR, SETUP_RESET);
        rchk(PORTE_ADDR, PORTE_RESET);
        wr(3'h7, 8'ha5);
        rchk(3'h7, 8'h00);
        wr(RESULT_ADDR, 8'hff);
        rchk(RESULT_ADDR, 8'h00);
        `CHK("power", 2'h0, cmpPowerOn)
    endtask
    task automatic t_select();
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                wr(SETUP1_ADDR, 8'h80 | 8'(p << 2) | 8'(k));
                wr(SETUP2_ADDR, 8'h80 | 8'(p << 2) | 8'(k));
                tick(4);
                rchk(RESULT_ADDR, {exp_res(1, p, k), exp_res(0, p, k),
                    6'h00});
            end
        end
        // Comparator 1 off while its inputs would give a high result.
        wr(SETUP1_ADDR, 8'h00);
        tick(4);
        rchk(RESULT_ADDR, {exp_res(1, 1, 3), 7'h00});
    endtask
    task automatic t_events();
        logic e;
        for (int iv = 0; iv < 2; iv++) begin
            for (int m = 0; m < 4; m++) begin
                volts[7:0] <= 8'h10;
                wr(SETUP1_ADDR, 8'h80 | 8'(iv << 5) | 8'(m << 3));
                for (int s = 0; s < 2; s++) begin
                    tick(5);
                    wr(FLAG_ADDR, 8'h00);
                    volts[7:0] <= s ? 8'h10 : 8'h40;
                    tick(5);
                    // The bench works out the adjusted edge from s and iv: rising when they match.
                    e = ((s == 0) != (iv == 1));
                    e = m == 3 || (m == 1 && e) || (m == 2 && !e);
                    rchk(FLAG_ADDR, {2'h0, 1'b0, e, 4'h0});
                end
            end
        end
    endtask
    task automatic t_irq();
        logic [7:0] core [3] = '{8'h80, 8'h40, 8'hc0};
        wr(SETUP1_ADDR, 8'h88);
        volts[7:0] <= 8'h10;
        tick(5);
        wr(FLAG_ADDR, 8'h00);
        wr(ENABLE_ADDR, 8'h00);
        wr(CORE_ADDR, 8'hc0);
        volts[7:0] <= 8'h40;
        tick(6);
        `CHK("irq", 1'b0, irqReq)
        rchk(FLAG_ADDR, 8'h10);
        wr(ENABLE_ADDR, 8'h10);
        for (int i = 0; i < 3; i++) begin
            wr(CORE_ADDR, core[i]);
            tick(3);
            `CHK("irq", i == 2, irqReq)
        end
        wr(FLAG_ADDR, 8'h00);
        tick(3);
        `CHK("irq", 1'b0, irqReq)
        wr(FLAG_ADDR, 8'h20);
        tick(3);
        `CHK("irq", 1'b0, irqReq)
        rchk(FLAG_ADDR, 8'h20);
        wr(ENABLE_ADDR, 8'h30);
        tick(3);
        `CHK("irq", 1'b1, irqReq)
    endtask
    task automatic t_pin();
        wr(SETUP1_ADDR, 8'hc0);
        wr(SETUP2_ADDR, 8'h80);
        wr(PORTE_ADDR, 8'hf9);
        tick(5);
        `CHK("pin", 2'h1, pinOut)
        `CHK("mux", 2'h1, pinMuxSel)
        `CHK("oe", 2'h3, pinOe)
        wr(SETUP1_ADDR, 8'he0);
        wr(PORTE_ADDR, 8'hfb);
        tick(5);
        `CHK("pin", 2'h0, pinOut)
        `CHK("oe", 2'h2, pinOe)
    endtask
    task automatic summarize();
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // A hang is cut short well beyond the few hundred cycles needed.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        tick(3);
        nrst <= 1'b1;
        tick(3);
        t_reset();
        t_select();
        t_events();
        t_irq();
        t_pin();
        nrst <= 1'b0;
        tick(3);
        nrst <= 1'b1;
        tick(3);
        t_reset();
        summarize();
    end
endmodule
